// ---- core/mfr_map.svh ----
// Opcodes, step counts and reset values of the multi-line fast read path
`ifndef MFR_MAP_SVH
`define MFR_MAP_SVH

`define MFR_OP_DUAL_OUT 8'h3B
`define MFR_OP_QUAD_OUT 8'h6B
`define MFR_OP_DUAL_IO 8'hBB
`define MFR_OP_DTR_DUAL_IO 8'hBD
`define MFR_OP_QUAD_IO 8'hEB
`define MFR_OP_SET_WRAP 8'h77

`define MFR_CMD_STEPS 6'h08
`define MFR_ADDR_STEPS_X1 6'h18
`define MFR_ADDR_STEPS_X2 6'h0C
`define MFR_ADDR_STEPS_X4 6'h06
`define MFR_MODE_STEPS_X2 6'h04
`define MFR_MODE_STEPS_X4 6'h02
`define MFR_WRAP_STEPS 6'h08
`define MFR_DUMMY_DUAL_OUT 6'h08
`define MFR_DUMMY_QUAD_OUT 6'h08
`define MFR_DUMMY_DUAL_IO 6'h00
`define MFR_DUMMY_DTR_DUAL 6'h04
`define MFR_DUMMY_QUAD_IO 6'h04
`define MFR_STEP_ONE 6'h01

`define MFR_MODE_CONT 2'h2
`define MFR_WRAP_RESET 3'h7
`define MFR_WRAP_MASK_8 6'h07
`define MFR_WRAP_MASK_16 6'h0F
`define MFR_WRAP_MASK_32 6'h1F
`define MFR_WRAP_MASK_64 6'h3F
`define MFR_BYTE_STEPS_X2 3'h3
`define MFR_BYTE_STEPS_X4 3'h1
`define MFR_OE_X2 4'h3
`define MFR_OE_X4 4'hF
`define MFR_IDLE_BYTE 8'hFF
`define MFR_SYNC_RESET 6'h20
`define MFR_ADDR_ONE 24'h00_0001

`endif

// ---- core/mfr_pkg.sv ----
// Types shared by the fast read path
package mfr_pkg;
  typedef enum logic [7:0] {
    MFR_ST_IDLE = 8'h01,
    MFR_ST_CMD = 8'h02,
    MFR_ST_ADDR = 8'h04,
    MFR_ST_MODE = 8'h08,
    MFR_ST_DUMMY = 8'h10,
    MFR_ST_DATA = 8'h20,
    MFR_ST_WRAP = 8'h40,
    MFR_ST_IGNORE = 8'h80
  } mfr_state_type;
endpackage

// ---- core/mfr_fifo.sv ----
// Byte FIFO between the array fetch and the serial output shifter
`timescale 1ns/1ps
module mfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = count != FULL;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // mfr_fifo

// ---- core/mfr_read_path.sv ----
// Multi-line fast read path: pin sampling, command sequencing, fetch and output
//
// Function
// R1 - Dual output read sends data on io_line_0 and io_line_1 together.
// R2 - Dual output read has eight dummy clocks; inputs ignored during them.
// R3 - Host releases io_line_0 before first data falling edge.
// R4 - Quad output read sends data on all four lines after single-line address.
// R5 - Quad output read rejected unless quad_enable_bit is one.
// R6 - Quad output read has eight dummy clocks; host releases lines first.
// R7 - Dual I/O reads move address and data two bits per clock.
// R8 - Eight read_mode_bits follow address; upper nibble decides, lower ignored.
// R9 - Dual I/O with mode_bits_5_4 of 10 skips next opcode.
// R10 - Host may leave dual continuous mode with sixteen ones on io_line_0.
// R11 - DTR dual I/O with mode_bits_5_4 of 10 skips next opcode.
// R12 - Host may leave DTR bypass with sixteen or twenty ones on io_line_0.
// R13 - Quad I/O moves address and data four bits per clock, four dummies.
// R14 - Quad I/O read accepted only while quad_enable_bit is set; code checks it only at the opcode, not in bypass frames.
// R15 - Quad I/O with mode_bits_5_4 of 10 takes address first next time.
// R16 - Host may leave quad continuous mode with eight ones on io_line_0.
// R17 - Latest wrap setting applies to every later quad I/O read.
// R18 - Wrap confines quad I/O reads to aligned 8/16/32/64 byte sections.
// R19 - Wrapped output steps upward, returns to section start, until deselect.
// R20 - Set-burst-with-wrap loads wrap_enable_bit and wrap_length_field.
// R21 - DTR reads sample address and drive data on both clock edges.
// R22 - Quad-lane instruction mode offers no wrap; not handled by this path.
// R23 - Continuous-read state survives deselect; cleared by other mode bits or reset.
`timescale 1ns/1ps
`include "mfr_map.svh"
module mfr_read_path import mfr_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_enable_bit,
  output logic mem_req_valid,
  output logic [23:0] mem_req_addr,
  input wire logic mem_rsp_valid,
  input wire logic [7:0] mem_rsp_data,
  output logic continuous_read_active,
  output logic [2:0] wrap_setting_bits
);
  mfr_state_type state;
  mfr_state_type next_state;
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic sclk_d;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [31:0] sr;
  logic [7:0] cmd;
  logic [7:0] obyte;
  logic [2:0] step;
  logic [23:0] fetch_addr;
  logic fetch_on;
  logic pending;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link clock edges
  // The link clock is only sampled, so it must stay well below a quarter of clk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_a <= `MFR_SYNC_RESET;
      sync_b <= `MFR_SYNC_RESET;
      sclk_d <= 1'b0;
    end else begin
      sync_a <= {cs_n, sclk, io_in};
      sync_b <= sync_a;
      sclk_d <= sync_b[4];
    end
  end

  wire cs_lo = ~sync_b[5];
  wire [3:0] io_s = sync_b[3:0];
  wire rise = sync_b[4] & ~sclk_d;
  wire fall = ~sync_b[4] & sclk_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire st_idle = state == MFR_ST_IDLE;
  wire st_cmd = state == MFR_ST_CMD;
  wire st_addr = state == MFR_ST_ADDR;
  wire st_mode = state == MFR_ST_MODE;
  wire st_dummy = state == MFR_ST_DUMMY;
  wire st_data = state == MFR_ST_DATA;
  wire st_wrap = state == MFR_ST_WRAP;
  wire [31:0] next_sr;
  wire [7:0] dec_op = st_cmd ? next_sr[7:0] : cmd;
  wire op_do = dec_op == `MFR_OP_DUAL_OUT;
  wire op_qo = dec_op == `MFR_OP_QUAD_OUT;
  wire op_dio = dec_op == `MFR_OP_DUAL_IO;
  wire op_ddr = dec_op == `MFR_OP_DTR_DUAL_IO;
  wire op_qio = dec_op == `MFR_OP_QUAD_IO;
  wire op_wrap = dec_op == `MFR_OP_SET_WRAP;
  wire op_read = op_do | op_qo | op_dio | op_ddr | op_qio;
  wire read_ok = op_read & (quad_enable_bit | ~(op_qo | op_qio)); // see R5 see R14
  wire has_mode = op_dio | op_ddr | op_qio; // see R8
  wire addr_x2 = op_dio | op_ddr; // see R7
  wire data_x2 = op_do | op_dio | op_ddr; // see R1
  wire [5:0] addr_steps = addr_x2 ? `MFR_ADDR_STEPS_X2 :
                          op_qio ? `MFR_ADDR_STEPS_X4 : `MFR_ADDR_STEPS_X1;
  wire [5:0] mode_steps = op_qio ? `MFR_MODE_STEPS_X4 : `MFR_MODE_STEPS_X2;
  wire [5:0] dummy_steps = op_do ? `MFR_DUMMY_DUAL_OUT : // see R2
                           op_qo ? `MFR_DUMMY_QUAD_OUT : // see R6
                           op_ddr ? `MFR_DUMMY_DTR_DUAL :
                           op_qio ? `MFR_DUMMY_QUAD_IO : `MFR_DUMMY_DUAL_IO; // see R13
  wire no_dummy = dummy_steps == '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Input shifting
  // Dummy clocks count rising edges only and never touch the shift register
  // The fall closing the last opcode clock comes before the first address rise; skip it
  wire dtr_in = op_ddr & ((st_addr & (cnt != `MFR_ADDR_STEPS_X2)) | st_mode); // see R21
  wire in_strobe = rise | (dtr_in & fall);
  wire shift_en = in_strobe & (st_cmd | st_addr | st_mode | st_wrap); // see R2
  wire lanes_x4 = st_wrap | (op_qio & (st_addr | st_mode)); // see R13
  wire lanes_x2 = addr_x2 & (st_addr | st_mode); // see R7
  assign next_sr = lanes_x4 ? {sr[27:0], io_s} :
                   lanes_x2 ? {sr[29:0], io_s[1:0]} : {sr[30:0], io_s[0]};
  wire last_step = in_strobe & (cnt == `MFR_STEP_ONE);
  wire addr_done = st_addr & last_step;
  wire mode_done = st_mode & last_step;
  wire cont_hit = next_sr[5:4] == `MFR_MODE_CONT; // see R8

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (in_strobe) begin
      next_cnt = cnt - `MFR_STEP_ONE;
    end
    case (state)
      MFR_ST_IDLE: begin
        if (cs_lo && continuous_read_active) begin
          next_state = MFR_ST_ADDR; // see R9 see R11 see R15
          next_cnt = addr_steps;
        end else if (cs_lo) begin
          next_state = MFR_ST_CMD;
          next_cnt = `MFR_CMD_STEPS;
        end
      end
      MFR_ST_CMD: begin
        if (last_step && read_ok) begin
          next_state = MFR_ST_ADDR;
          next_cnt = addr_steps;
        end else if (last_step && op_wrap) begin
          next_state = MFR_ST_WRAP;
          next_cnt = `MFR_WRAP_STEPS;
        end else if (last_step) begin
          next_state = MFR_ST_IGNORE; // see R5 see R14
        end
      end
      MFR_ST_ADDR: begin
        if (last_step && has_mode) begin
          next_state = MFR_ST_MODE;
          next_cnt = mode_steps;
        end else if (last_step && no_dummy) begin
          next_state = MFR_ST_DATA;
        end else if (last_step) begin
          next_state = MFR_ST_DUMMY;
          next_cnt = dummy_steps;
        end
      end
      MFR_ST_MODE: begin
        if (last_step && no_dummy) begin
          next_state = MFR_ST_DATA;
        end else if (last_step) begin
          next_state = MFR_ST_DUMMY;
          next_cnt = dummy_steps;
        end
      end
      MFR_ST_DUMMY: begin
        if (last_step) begin
          next_state = MFR_ST_DATA;
        end
      end
      MFR_ST_WRAP: begin
        if (last_step) begin
          next_state = MFR_ST_IGNORE;
        end
      end
      MFR_ST_DATA: begin
        next_state = MFR_ST_DATA;
      end
      MFR_ST_IGNORE: begin
        next_state = MFR_ST_IGNORE;
      end
      default: begin
        next_state = MFR_ST_IDLE;
      end
    endcase
    if (!cs_lo) begin
      next_state = MFR_ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= MFR_ST_IDLE;
      cnt <= '0;
      sr <= '0;
      cmd <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (shift_en) begin
        sr <= next_sr;
      end
      if (st_cmd && last_step) begin
        cmd <= next_sr[7:0];
      end
    end
  end

  // Bypass state outlives deselect, so a stray deselect mid-read keeps it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      continuous_read_active <= 1'b0;
      wrap_setting_bits <= `MFR_WRAP_RESET;
    end else begin
      if (mode_done) begin
        continuous_read_active <= cont_hit; // see R9 see R11 see R15 see R23
      end
      if (st_wrap && last_step) begin
        wrap_setting_bits <= next_sr[6:4]; // see R17 see R20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array fetch with section wrap
  wire wrap_on = op_qio & ~wrap_setting_bits[0]; // see R17 see R22
  wire [5:0] wrap_mask = wrap_setting_bits[2:1] == 2'h0 ? `MFR_WRAP_MASK_8 :
                         wrap_setting_bits[2:1] == 2'h1 ? `MFR_WRAP_MASK_16 :
                         wrap_setting_bits[2:1] == 2'h2 ? `MFR_WRAP_MASK_32 :
                         `MFR_WRAP_MASK_64; // see R18
  wire [23:0] fetch_inc = fetch_addr + `MFR_ADDR_ONE;
  wire [5:0] wrap_low = (fetch_addr[5:0] & ~wrap_mask) | (fetch_inc[5:0] & wrap_mask);
  wire [23:0] next_fetch = wrap_on ? {fetch_addr[23:6], wrap_low} : fetch_inc; // see R19
  wire fifo_clear = addr_done | ~cs_lo;
  // One request in flight at a time, so free space seen at issue is still free
  wire issue = fetch_on & ~pending & ~mem_req_valid & fifo_in_ready & ~fifo_clear;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fetch_on <= 1'b0;
      fetch_addr <= '0;
      pending <= 1'b0;
      mem_req_valid <= 1'b0;
      mem_req_addr <= '0;
    end else begin
      mem_req_valid <= issue;
      if (addr_done) begin
        fetch_on <= 1'b1;
        fetch_addr <= next_sr[23:0];
      end else if (!cs_lo) begin
        fetch_on <= 1'b0;
      end else if (issue) begin
        fetch_addr <= next_fetch;
      end
      if (issue) begin
        mem_req_addr <= fetch_addr;
        pending <= 1'b1;
      end else if (mem_rsp_valid) begin
        pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output shifter
  wire out_strobe = st_data & (fall | (op_ddr & rise)); // see R21
  wire need_byte = out_strobe & (step == '0);
  // An empty FIFO on demand shows an idle byte rather than stalling the link
  wire [7:0] out_src = !need_byte ? obyte :
                       fifo_out_valid ? fifo_out_data : `MFR_IDLE_BYTE;
  wire [3:0] next_io = data_x2 ? {2'h0, out_src[7:6]} : out_src[7:4]; // see R1 see R4
  wire [7:0] next_obyte = data_x2 ? {out_src[5:0], 2'h0} : {out_src[3:0], 4'h0};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_out <= '0;
      io_oe <= '0;
      obyte <= '0;
      step <= '0;
    end else if (!cs_lo) begin
      io_oe <= '0;
      step <= '0;
    end else if (out_strobe) begin
      io_out <= next_io;
      io_oe <= data_x2 ? `MFR_OE_X2 : `MFR_OE_X4; // see R1 see R4 see R7
      obyte <= next_obyte;
      step <= need_byte ? (data_x2 ? `MFR_BYTE_STEPS_X2 : `MFR_BYTE_STEPS_X4) : step - 3'h1;
    end
  end

  mfr_fifo #(
    .WIDTH(8),
    .DEPTH(32)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .clear(fifo_clear),
    .in_valid(mem_rsp_valid & fetch_on),
    .in_ready(fifo_in_ready),
    .in_data(mem_rsp_data),
    .out_valid(fifo_out_valid),
    .out_ready(need_byte),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  localparam int OE_LO = 1;
  localparam int OE_HI = 2;

  a_dual_lanes: assert property (st_data && data_x2 && io_oe != '0 |-> io_oe == 4'h3) // see R1
    else $error("dual read drives wrong lanes");
  a_quad_lanes: assert property (st_data && op_qo && io_oe != '0 |-> io_oe == 4'hF) // see R4
    else $error("quad read drives wrong lanes");
  a_dummy_quiet: assert property (st_dummy && cs_lo |=> $stable(sr)) // see R2
    else $error("input shifted during dummy clocks");
  a_quad_reject: assert property (st_cmd && last_step && (op_qo || op_qio) &&
    !quad_enable_bit && cs_lo |=> state == MFR_ST_IGNORE) // see R5
    else $error("quad read accepted without quad enable");
  a_quad_accept: assert property (st_cmd && last_step && op_qio && quad_enable_bit &&
    cs_lo |=> st_addr && cnt == 6'h06) // see R14
    else $error("quad io read not accepted");
  a_bypass_set: assert property (mode_done |=>
    continuous_read_active == $past(cont_hit)) // see R9
    else $error("mode bits not applied");
  a_bypass_skip: assert property (st_idle && cs_lo && continuous_read_active |=>
    st_addr && cmd == $past(cmd)) // see R15
    else $error("bypass did not skip opcode");
  a_bypass_hold: assert property ($rose(sync_b[5]) |=> $stable(continuous_read_active)
    [*2]) // see R23
    else $error("continuous state lost on deselect");
  a_wrap_load: assert property (st_wrap && last_step |=>
    wrap_setting_bits == $past(next_sr[6:4])) // see R20
    else $error("wrap bits not loaded");
  a_wrap_bound: assert property (issue && wrap_on && !addr_done |=>
    (fetch_addr[5:0] & ~wrap_mask) == ($past(fetch_addr[5:0]) & ~wrap_mask) &&
    fetch_addr[23:6] == $past(fetch_addr[23:6])) // see R18 see R19
    else $error("wrapped fetch left its section");
  a_dtr_edges: assert property (st_addr && op_ddr && fall && cs_lo &&
    cnt != `MFR_ADDR_STEPS_X2 |=> sr == $past(next_sr)) // see R21
    else $error("falling edge not sampled in dtr");
  a_oe_release: assert property (!cs_lo |-> ##[OE_LO:OE_HI] io_oe == '0) // see R7
    else $error("lines driven after deselect");

  c_quad_io_data: cover property (st_data && op_qio && out_strobe);
  c_dtr_data: cover property (st_data && op_ddr && out_strobe);
  c_bypass: cover property (st_idle && cs_lo && continuous_read_active);
  c_wrap_turn: cover property (issue && wrap_on && (fetch_addr[5:0] & wrap_mask) == wrap_mask);
endmodule // mfr_read_path

// ---- sim/mfr_host_model.sv ----
// Host controller model: drives select, link clock and io lines
`timescale 1ns/1ps
module mfr_host_model (
  input wire logic clk,
  input wire logic [3:0] io_wire,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_drv,
  output logic [3:0] io_en
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_drv = 4'h0;
    io_en = 4'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Link clock stands low outside frames
  task automatic sel();
    sclk = 1'b0;
    cs_n = 1'b0;
    wait_clk(4);
  endtask
  task automatic desel();
    wait_clk(4);
    io_en = 4'h0;
    cs_n = 1'b1;
    wait_clk(16);
  endtask
  // Msb first, the higher bit on the higher line
  task automatic shift(input int lanes, input int nbits, input logic [31:0] v, input bit dtr);
    int i;
    logic [3:0] m;
    m = (lanes == 4) ? 4'hF : (lanes == 2) ? 4'h3 : 4'h1;
    io_en = m;
    for (i = nbits - lanes; i >= 0; i -= lanes) begin
      wait_clk(2);
      io_drv = 4'(v >> i) & m;
      wait_clk(2);
      sclk = ~sclk;
      if (!dtr) begin
        wait_clk(4);
        // Released before the fall, since data may follow the mode bits directly
        if (i == 0) io_en = 4'h0;
        sclk = 1'b0;
      end
    end
  endtask
  // Junk during dummies, lines released ahead of the first data fall
  task automatic dummy(input int n);
    int k;
    for (k = 0; k < n; k++) begin
      wait_clk(2);
      io_drv = ~io_drv;
      if (k == n - 1) io_en = 4'h0;
      wait_clk(2);
      sclk = 1'b1;
      wait_clk(4);
      sclk = 1'b0;
    end
  endtask
  task automatic rd_byte(input int lanes, input bit dtr, output logic [7:0] b);
    int c;
    logic [3:0] m;
    m = (lanes == 4) ? 4'hF : 4'h3;
    b = 8'h00;
    for (c = 0; c < 8 / lanes; c++) begin
      wait_clk(4);
      b = (b << lanes) | 8'(io_wire & m);
      sclk = ~sclk;
      if (!dtr) begin
        wait_clk(4);
        sclk = 1'b0;
      end
    end
  endtask
endmodule // mfr_host_model

// ---- sim/test_mfr_read_path.sv ----
// Testbench of the multi-line fast read path
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module test_mfr_read_path;
  logic clk = 1'b0;
  logic reset, quad_enable_bit;
  logic mem_rsp_valid = 1'b0;
  logic d1 = 1'b0;
  logic [7:0] mem_rsp_data = 8'h00;
  logic [23:0] a1 = 24'h00_0000;
  logic [23:0] mem_req_addr;
  logic cs_n, sclk, mem_req_valid, continuous_read_active;
  logic [3:0] host_drv, host_en, io_out, io_oe;
  logic [3:0] flt = 4'h5;
  logic [2:0] wrap_setting_bits;
  wire logic [3:0] io_in;
  int n_fail = 0;
  int total_checks = 0;
  int wmask = 0;
  always #12.5 clk = ~clk;
  // Undriven lines toggle so a stale value can never pass
  assign io_in = (io_oe & io_out) | (~io_oe & host_en & host_drv) | (~io_oe & ~host_en & flt);
  always @(negedge clk) begin
    flt <= ~flt;
    d1 <= mem_req_valid & ~reset;
    a1 <= mem_req_addr;
    mem_rsp_valid <= d1;
    mem_rsp_data <= a1[7:0] ^ 8'hA5;
  end
  mfr_read_path dut (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit),
    .mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
    .continuous_read_active(continuous_read_active), .wrap_setting_bits(wrap_setting_bits));
  mfr_host_model host (.clk(clk), .io_wire(io_in), .cs_n(cs_n), .sclk(sclk),
    .io_drv(host_drv), .io_en(host_en));
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  task automatic rd(input logic [7:0] op, input bit skip, input logic [23:0] a,
    input logic [7:0] mode, input int n, input bit ok);
    int la, ld, nd, k;
    bit dtr;
    logic [7:0] b;
    logic [23:0] ea;
    logic [3:0] eoe;
    la = 1;
    ld = 2;
    nd = 8;
    dtr = 1'b0;
    case (op)
      8'h6B: ld = 4;
      8'hBB: begin
        la = 2;
        nd = 0;
      end
      8'hBD: begin
        la = 2;
        nd = 4;
        dtr = 1'b1;
      end
      8'hEB: begin
        la = 4;
        ld = 4;
        nd = 4;
      end
      default: ;
    endcase
    eoe = ok ? ((ld == 4) ? 4'hF : 4'h3) : 4'h0;
    host.sel();
    if (!skip) host.shift(1, 8, {24'h0, op}, 1'b0);
    host.shift(la, 24, {8'h0, a}, dtr);
    if (la > 1) host.shift(la, 8, {24'h0, mode}, dtr);
    host.dummy(nd);
    for (k = 0; k < n; k++) begin
      ea = a + 24'(k);
      if (op == 8'hEB && wmask != 0) ea = (a & ~24'(wmask)) | (ea & 24'(wmask));
      host.rd_byte(ld, dtr, b);
      `CHK("io_oe", io_oe, eoe)
      if (ok) `CHK("data", b, exp_byte(ea))
    end
    host.desel();
  endtask
  task automatic wr_wrap(input logic [7:0] w);
    host.sel();
    host.shift(1, 8, 32'h0000_0077, 1'b0);
    host.shift(4, 32, {24'h0, w}, 1'b0);
    host.desel();
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    quad_enable_bit = 1'b0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("io_oe", io_oe, 4'h0)
    `CHK("cont", continuous_read_active, 1'b0)
    `CHK("wrap", wrap_setting_bits, 3'h7)
    $display("test reset done");
    rd(8'h3B, 0, 24'h00_0010, 8'h00, 3, 1);
    $display("test dual output done");
    rd(8'h6B, 0, 24'h00_0020, 8'h00, 1, 0);
    quad_enable_bit = 1'b1;
    rd(8'h6B, 0, 24'h00_00FE, 8'h00, 3, 1);
    $display("test quad output done");
    rd(8'hBB, 0, 24'h00_0040, 8'h2C, 2, 1);
    `CHK("cont", continuous_read_active, 1'b1)
    rd(8'hBB, 1, 24'h00_0080, 8'hFF, 2, 1);
    `CHK("cont", continuous_read_active, 1'b0)
    $display("test dual io done");
    rd(8'hBD, 0, 24'h00_0033, 8'h25, 2, 1);
    `CHK("cont", continuous_read_active, 1'b1)
    rd(8'hBD, 1, 24'h00_0044, 8'hFF, 2, 1);
    `CHK("cont", continuous_read_active, 1'b0)
    $display("test dtr dual io done");
    quad_enable_bit = 1'b0;
    rd(8'hEB, 0, 24'h00_0050, 8'h20, 1, 0);
    `CHK("cont", continuous_read_active, 1'b0)
    quad_enable_bit = 1'b1;
    wr_wrap(8'h10);
    `CHK("wrap", wrap_setting_bits, 3'h1)
    wr_wrap(8'h20);
    `CHK("wrap", wrap_setting_bits, 3'h2)
    wmask = 15;
    rd(8'hEB, 0, 24'h00_010E, 8'h20, 4, 1);
    `CHK("cont", continuous_read_active, 1'b1)
    rd(8'hEB, 1, 24'h00_012E, 8'hFF, 3, 1);
    `CHK("cont", continuous_read_active, 1'b0)
    $display("test quad io done");
    wr_wrap(8'h00);
    `CHK("wrap", wrap_setting_bits, 3'h0)
    wmask = 7;
    rd(8'hEB, 0, 24'h00_0206, 8'hFF, 3, 1);
    wr_wrap(8'h40);
    `CHK("wrap", wrap_setting_bits, 3'h4)
    wmask = 31;
    rd(8'hEB, 0, 24'h00_033E, 8'hFF, 3, 1);
    wr_wrap(8'h60);
    `CHK("wrap", wrap_setting_bits, 3'h6)
    wmask = 63;
    rd(8'hEB, 0, 24'h00_047E, 8'hFF, 3, 1);
    wr_wrap(8'h10);
    wmask = 0;
    rd(8'hEB, 0, 24'h00_05FF, 8'h20, 2, 1);
    `CHK("cont", continuous_read_active, 1'b1)
    // Reset in mid-run must drop the bypass state and the wrap setting
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("cont", continuous_read_active, 1'b0)
    `CHK("wrap", wrap_setting_bits, 3'h7)
    $display("test wrap lengths and reset done");
    print_verdict();
  end
endmodule // test_mfr_read_path
